//--- hw/csf_flag_unit.sv
// One channel of status flags, updated once per scan
`timescale 1ns/10ps
module csf_flag_unit
(
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	input  wire logic                 scanTick,
	input  wire logic                 update,
	input  wire logic                 present,
	input  wire csf_pkg::csf_chan_in_t chanIn,
	input  wire logic                 extA,
	input  wire logic                 extB,
	output csf_pkg::csf_flags_t       flags
);

	typedef struct packed {
		csf_pkg::csf_flags_t flags;
		logic                pendDone;
		logic                pendClr;
	} csf_unit_state_t;

	csf_unit_state_t st_r;
	csf_unit_state_t st_nxt;

	assign flags = st_r.flags;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	// Home events are held until the scan so none is lost between scans
	always_comb
	begin
		st_nxt = st_r;
		if (chanIn.homeClr || !present)
		begin
			st_nxt.pendClr  = 1'b1;
			st_nxt.pendDone = 1'b0;
		end
		else if (chanIn.homeDone)
		begin
			st_nxt.pendDone = 1'b1;
		end
		if (scanTick && update)
		begin
			st_nxt.pendClr  = 1'b0;
			st_nxt.pendDone = 1'b0;
			if (!present)
			begin
				st_nxt.flags = '0;
			end
			else
			begin
				st_nxt.flags.permit = chanIn.permit;
				st_nxt.flags.dirNeg = chanIn.dirNeg;
				// Clear first; a new completed search is needed after it
				if (st_r.pendClr || chanIn.homeClr)
				begin
					st_nxt.flags.home = 1'b0;
				end
				else if (st_r.pendDone || chanIn.homeDone)
				begin
					st_nxt.flags.home = 1'b1;
				end
				// A drive fault forces the state pair to both low
				{st_nxt.flags.driveHi, st_nxt.flags.driveLo} =
					chanIn.fault ? csf_pkg::DRIVE_OFF : chanIn.drive;
				st_nxt.flags.extA  = extA;
				st_nxt.flags.extB  = extB;
				st_nxt.flags.inPos = chanIn.inPos;
			end
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

endmodule

//--- hw/csf_status_flags.sv
// Axis and spindle status flags for the logic controller, Wishbone registers
`timescale 1ns/10ps
// Notes on behaviour
// - Strobe goes high when a new tool-return code is placed in its register.
// - Tool-return information is given only while config bit 12 is set.
// - Flags of unconfigured axes always read zero.
// - Axis flag index follows logical order of configured axes, not slot.
// - Axis move-permit flag high lets the axis move; blocks spaced fifty.
// - Axis direction flag high for negative travel, low for positive.
// - Home-done set after search; cleared at reset, operator reset, alarms, losses.
// - A cleared home-done flag returns only after a new home search.
// - Drive-state pair: 00 self-test, 01 bus ready, 10 enabling, 11 running.
// - Drive internal fault forces both drive-state flags low.
// - Gantry flag high when pair difference exceeds the configured limit.
// - Short-move flag high when commanded move is below minimum move.
// - Axis in-position flag high when that axis reached position.
// - Only the selected spindle's flag set is updated.
// - Closed loop: spindle permit high allows motion; direction high negative.
// - Spindle home-done cleared at reset, alarms, closed-to-open switch.
// - Each spindle has its own drive-state pair with axis encoding and fault.
// - Rotary-axis flag high while selected spindle works as rotary axis.
// - CW or CCW mode: speed-ok high when speed within low and high limits.
// - Closed loop: speed-ok high only while the spindle is stopped.
// - Closed loop: spindle in-position high when spindle reached position.
module csf_status_flags
(
	input  wire logic                                     sys_clk,
	input  wire logic                                     rst_n,
	// Wishbone classic slave
	input  wire logic                                     wbCyc,
	input  wire logic                                     wbStb,
	input  wire logic                                     wbWe,
	input  wire logic [31:0]                              wbAdr,
	input  wire logic [3:0]                               wbSel,
	input  wire logic [31:0]                              wbDatW,
	output logic      [31:0]                              wbDatR,
	output logic                                          wbAck,
	// Motion core status
	input  wire logic                                     scanTick,
	input  wire logic                                     operatorReset,
	input  wire logic                                     paramChange,
	input  wire logic [csf_pkg::AXES-1:0]                 axisConfigured,
	input  wire csf_pkg::csf_chan_in_t                    axisIn [csf_pkg::AXES],
	input  wire logic [csf_pkg::MAG_W-1:0]                axisMoveMag [csf_pkg::AXES],
	input  wire logic [csf_pkg::MAG_W-1:0]                axisGantryDiff [csf_pkg::AXES],
	input  wire logic [csf_pkg::MAG_W-1:0]                axisLossUm [csf_pkg::AXES],
	input  wire csf_pkg::csf_chan_in_t                    spindleIn,
	input  wire csf_pkg::csf_spin_mode_t                  spindleMode,
	input  wire logic [csf_pkg::MAG_W-1:0]                spindleSpeed,
	input  wire logic                                     spindleStopped,
	input  wire logic                                     toolReturnValid,
	input  wire logic [csf_pkg::CODE_W-1:0]               toolReturnCode,
	// Flags to the logic controller
	output csf_pkg::csf_flags_t                           axisFlags [csf_pkg::AXES],
	output csf_pkg::csf_flags_t                           spindleFlags [csf_pkg::SPINDLES],
	output logic                                          tool_return_strobe,
	output logic      [csf_pkg::CODE_W-1:0]               tool_return_code_reg
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic                            ack;
		logic [31:0]                     datR;
		logic [31:0]                     ctrl;
		logic [15:0]                     min_move_param;
		logic [15:0]                     gantryLimit;
		logic [15:0]                     spdLow;
		logic [15:0]                     spdHigh;
		logic [csf_pkg::CODE_W-1:0]      toolCode;
		logic                            toolStrobe;
		logic                            toolNew;
		csf_pkg::csf_spin_mode_t         prevMode;
	} csf_top_state_t;

	csf_top_state_t st_r;
	csf_top_state_t st_nxt;

	csf_pkg::csf_chan_in_t mapIn [csf_pkg::AXES];
	logic                  mapPresent [csf_pkg::AXES];
	logic                  mapGantry [csf_pkg::AXES];
	logic                  mapShort [csf_pkg::AXES];
	csf_pkg::csf_chan_in_t spinCh;
	logic                  spinRotary;
	logic                  spinSpeedOk;
	logic                  spinSel;
	logic                  closedToOpen;
	logic                  regHit;
	logic [31:0]           rdMux;

	assign wbAck                = st_r.ack;
	assign wbDatR               = st_r.datR;
	assign tool_return_strobe   = st_r.toolStrobe;
	assign tool_return_code_reg = st_r.toolCode;
	assign spinSel              = st_r.ctrl[csf_pkg::CTRL_SPIN_SEL_BIT];

	// Byte-lane write merge
	function automatic logic [31:0] laneMerge(input logic [31:0] oldV,
		input logic [31:0] newV, input logic [3:0] sel);
		logic [31:0] res;
		res = oldV;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
			begin
				res[b*8 +: 8] = newV[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// ---------------------------------------------------------------
	// Axis ordering
	// ---------------------------------------------------------------
	// Configured slots are packed down so index k is the k-th real axis
	always_comb
	begin
		logic [2:0] k;
		logic       lossHit;
		k = 3'h0;
		lossHit = 1'b0;
		for (int i = 0; i < csf_pkg::AXES; i++)
		begin
			mapIn[i]      = '0;
			mapPresent[i] = 1'b0;
			mapGantry[i]  = 1'b0;
			mapShort[i]   = 1'b0;
		end
		for (int s = 0; s < csf_pkg::AXES; s++)
		begin
			if (axisConfigured[s])
			begin
				lossHit = axisLossUm[s] > csf_pkg::HOME_LOSS_UM;
				mapIn[k]         = axisIn[s];
				mapIn[k].homeClr = axisIn[s].homeClr || lossHit
					|| operatorReset || paramChange;
				mapPresent[k]    = 1'b1;
				mapGantry[k]     = axisGantryDiff[s] > st_r.gantryLimit;
				mapShort[k]      = axisMoveMag[s] < st_r.min_move_param;
				k = k + 3'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Axis flag units
	// ---------------------------------------------------------------
	// Unconfigured indices get present low and so read zero
	generate
		for (genvar g = 0; g < csf_pkg::AXES; g++)
		begin : gAxis
			csf_flag_unit uAxis
			(
				.sys_clk  (sys_clk),
				.rst_n    (rst_n),
				.scanTick (scanTick),
				.update   (1'b1),
				.present  (mapPresent[g]),
				.chanIn   (mapIn[g]),
				.extA     (mapGantry[g]),
				.extB     (mapShort[g]),
				.flags    (axisFlags[g])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Selected spindle conditioning
	// ---------------------------------------------------------------
	// Permit, direction and in-position only mean something in closed loop
	always_comb
	begin
		closedToOpen   = st_r.prevMode == csf_pkg::SPM_CLOSED
			&& spindleMode != csf_pkg::SPM_CLOSED;
		spinCh         = spindleIn;
		spinCh.permit  = spindleMode == csf_pkg::SPM_CLOSED && spindleIn.permit;
		spinCh.dirNeg  = spindleMode == csf_pkg::SPM_CLOSED && spindleIn.dirNeg;
		spinCh.inPos   = spindleMode == csf_pkg::SPM_CLOSED && spindleIn.inPos;
		spinCh.homeClr = spindleIn.homeClr || operatorReset || closedToOpen;
		spinRotary     = spindleMode == csf_pkg::SPM_ROTARY;
		case (spindleMode)
			csf_pkg::SPM_CW,
			csf_pkg::SPM_CCW:
				spinSpeedOk = spindleSpeed >= st_r.spdLow
					&& spindleSpeed <= st_r.spdHigh;
			csf_pkg::SPM_CLOSED:
				spinSpeedOk = spindleStopped;
			default:
				spinSpeedOk = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// Spindle flag units
	// ---------------------------------------------------------------
	// Events reach only the selected spindle; the other holds its flags
	generate
		for (genvar g = 0; g < csf_pkg::SPINDLES; g++)
		begin : gSpin
			logic                  isSel;
			csf_pkg::csf_chan_in_t chIn;
			assign isSel = spinSel == 1'(g);
			assign chIn  = isSel ? spinCh : '0;
			csf_flag_unit uSpin
			(
				.sys_clk  (sys_clk),
				.rst_n    (rst_n),
				.scanTick (scanTick),
				.update   (isSel),
				.present  (1'b1),
				.chanIn   (chIn),
				.extA     (spinRotary),
				.extB     (spinSpeedOk),
				.flags    (spindleFlags[g])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Register read mux
	// ---------------------------------------------------------------
	// Unmapped addresses answer with zero so the master never hangs
	always_comb
	begin
		regHit = 1'b1;
		rdMux  = 32'h0000_0000;
		if (wbAdr[31:8] != 24'h00_0000)
		begin
			regHit = 1'b0;
		end
		else if (wbAdr[7:0] == csf_pkg::OFF_CTRL)
		begin
			rdMux = st_r.ctrl & csf_pkg::CTRL_MASK;
		end
		else if (wbAdr[7:0] == csf_pkg::OFF_MIN_MOVE)
		begin
			rdMux[15:0] = st_r.min_move_param;
		end
		else if (wbAdr[7:0] == csf_pkg::OFF_GANTRY_LIM)
		begin
			rdMux[15:0] = st_r.gantryLimit;
		end
		else if (wbAdr[7:0] == csf_pkg::OFF_SPD_LOW)
		begin
			rdMux[15:0] = st_r.spdLow;
		end
		else if (wbAdr[7:0] == csf_pkg::OFF_SPD_HIGH)
		begin
			rdMux[15:0] = st_r.spdHigh;
		end
		else if (wbAdr[7:0] == csf_pkg::OFF_AXIS_LO)
		begin
			rdMux = {axisFlags[3], axisFlags[2], axisFlags[1], axisFlags[0]};
		end
		else if (wbAdr[7:0] == csf_pkg::OFF_AXIS_HI)
		begin
			rdMux[23:0] = {axisFlags[6], axisFlags[5], axisFlags[4]};
		end
		else if (wbAdr[7:0] == csf_pkg::OFF_SPINDLE)
		begin
			rdMux[15:0] = {spindleFlags[1], spindleFlags[0]};
		end
		else if (wbAdr[7:0] == csf_pkg::OFF_TOOL_RET)
		begin
			rdMux[csf_pkg::CODE_W-1:0]       = st_r.toolCode;
			rdMux[csf_pkg::TOOL_STROBE_BIT]  = st_r.toolStrobe;
		end
		else
		begin
			regHit = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb
	begin
		logic req;
		logic wr;
		logic [31:0] mrg;
		mrg             = 32'h0000_0000;
		st_nxt          = st_r;
		st_nxt.prevMode = spindleMode;
		req             = wbCyc && wbStb && !st_r.ack;
		wr              = req && wbWe && regHit;

		// One-cycle ack; a request still held after its ack is answered again every second cycle
		st_nxt.ack  = req;
		st_nxt.datR = req && !wbWe ? rdMux : 32'h0000_0000;
		if (wr && wbAdr[7:0] == csf_pkg::OFF_CTRL)
		begin
			st_nxt.ctrl = laneMerge(st_r.ctrl, wbDatW, wbSel) & csf_pkg::CTRL_MASK;
		end
		if (wr && wbAdr[7:0] == csf_pkg::OFF_MIN_MOVE)
		begin
			mrg = laneMerge({16'h0000, st_r.min_move_param}, wbDatW, wbSel);
			st_nxt.min_move_param = mrg[15:0];
		end
		if (wr && wbAdr[7:0] == csf_pkg::OFF_GANTRY_LIM)
		begin
			mrg = laneMerge({16'h0000, st_r.gantryLimit}, wbDatW, wbSel);
			st_nxt.gantryLimit = mrg[15:0];
		end
		if (wr && wbAdr[7:0] == csf_pkg::OFF_SPD_LOW)
		begin
			mrg = laneMerge({16'h0000, st_r.spdLow}, wbDatW, wbSel);
			st_nxt.spdLow = mrg[15:0];
		end
		if (wr && wbAdr[7:0] == csf_pkg::OFF_SPD_HIGH)
		begin
			mrg = laneMerge({16'h0000, st_r.spdHigh}, wbDatW, wbSel);
			st_nxt.spdHigh = mrg[15:0];
		end

		// Tool return: code caught at once, strobe shown for one full scan
		if (toolReturnValid && st_r.ctrl[csf_pkg::CTRL_TOOL_RET_BIT])
		begin
			st_nxt.toolCode = toolReturnCode;
			st_nxt.toolNew  = 1'b1;
		end
		if (scanTick)
		begin
			st_nxt.toolStrobe = st_r.toolNew;
			// A code arriving on the scan edge itself is kept for the next one
			st_nxt.toolNew    = toolReturnValid
				&& st_r.ctrl[csf_pkg::CTRL_TOOL_RET_BIT];
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			st_r             <= '0;
			st_r.ctrl        <= csf_pkg::CTRL_RST;
			st_r.min_move_param     <= csf_pkg::PARAM_RST;
			st_r.gantryLimit <= csf_pkg::PARAM_RST;
			st_r.spdLow      <= csf_pkg::PARAM_RST;
			st_r.spdHigh     <= csf_pkg::PARAM_RST;
			st_r.prevMode    <= csf_pkg::SPM_OFF;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

endmodule

//--- include/csf_pkg.sv
// Constants and types shared by the axis and spindle status-flag block
package csf_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int AXES     = 7;
	localparam int SPINDLES = 2;
	localparam int MAG_W    = 16;
	localparam int CODE_W   = 8;
	localparam int FLAG_W   = 8;

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL       = 8'h00;
	localparam logic [7:0] OFF_MIN_MOVE   = 8'h04;
	localparam logic [7:0] OFF_GANTRY_LIM = 8'h08;
	localparam logic [7:0] OFF_SPD_LOW    = 8'h0C;
	localparam logic [7:0] OFF_SPD_HIGH   = 8'h10;
	localparam logic [7:0] OFF_AXIS_LO    = 8'h14;
	localparam logic [7:0] OFF_AXIS_HI    = 8'h18;
	localparam logic [7:0] OFF_SPINDLE    = 8'h1C;
	localparam logic [7:0] OFF_TOOL_RET   = 8'h20;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int          CTRL_SPIN_SEL_BIT = 0;
	localparam int          CTRL_TOOL_RET_BIT = 12;
	localparam logic [31:0] CTRL_MASK         = 32'h0000_1001;
	localparam logic [31:0] CTRL_RST          = 32'h0000_0000;
	localparam logic [15:0] PARAM_RST         = 16'h0000;
	localparam int          TOOL_STROBE_BIT   = 8;
	localparam logic [15:0] HOME_LOSS_UM      = 16'h000A;
	localparam logic [1:0]  DRIVE_OFF         = 2'h0;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		SPM_OFF,
		SPM_CW,
		SPM_CCW,
		SPM_CLOSED,
		SPM_ROTARY
	} csf_spin_mode_t;

	// Raw status of one axis or spindle from the motion core
	typedef struct packed {
		logic       permit;
		logic       dirNeg;
		logic       homeDone;
		logic       homeClr;
		logic [1:0] drive;
		logic       fault;
		logic       inPos;
	} csf_chan_in_t;

	// Flag byte seen by the logic controller, permit in bit 0
	typedef struct packed {
		logic       inPos;
		logic       extB;
		logic       extA;
		logic       driveLo;
		logic       driveHi;
		logic       home;
		logic       dirNeg;
		logic       permit;
	} csf_flags_t;

endpackage

//--- sim/csf_plc_model.sv
// Logic controller model that reads the status marks once per scan
`timescale 1ns/10ps
module csf_plc_model
(
	input wire logic                sys_clk,
	input wire logic                scanTick,
	input wire csf_pkg::csf_flags_t axisFlags [csf_pkg::AXES],
	input wire csf_pkg::csf_flags_t spindleFlags [csf_pkg::SPINDLES],
	input wire logic                tool_return_strobe,
	output logic [72:0]             marks
);
	logic scanSeen_r;

	// Read one cycle after the scan, once the marks have settled
	always_ff @(posedge sys_clk)
	begin
		scanSeen_r <= scanTick;
		if (scanSeen_r)
		begin
			for (int k = 0; k < csf_pkg::AXES; k++)
				marks[k*8 +: 8] <= axisFlags[k];
			marks[71:56] <= {spindleFlags[1], spindleFlags[0]};
			marks[72] <= tool_return_strobe;
		end
	end
endmodule

//--- sim/csf_status_flags_assertions.sv
// Port-level concurrent checks for the status-flag block
`timescale 1ns/10ps
module csf_status_flags_chk
(
	input wire logic                     sys_clk,
	input wire logic                     rst_n,
	input wire logic                     wbCyc,
	input wire logic                     wbStb,
	input wire logic [31:0]              wbDatR,
	input wire logic                     wbAck,
	input wire logic                     scanTick,
	input wire logic [csf_pkg::AXES-1:0] axisConfigured,
	input wire csf_pkg::csf_chan_in_t    axisIn [csf_pkg::AXES],
	input wire csf_pkg::csf_spin_mode_t  spindleMode,
	input wire logic                     spindleStopped,
	input wire csf_pkg::csf_flags_t      axisFlags [csf_pkg::AXES],
	input wire csf_pkg::csf_flags_t      spindleFlags [csf_pkg::SPINDLES],
	input wire logic                     tool_return_strobe
);
	// ----------------------------------------------------------
	// Bus timing and flag relations
	// ----------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	chk_ack_answer: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
		else $error("request not acknowledged one cycle later");
	chk_ack_pulse: assert property (wbAck |=> !wbAck)
		else $error("acknowledge longer than one cycle");
	chk_read_idle: assert property (!wbAck |-> wbDatR == 32'h0000_0000)
		else $error("read data not zero outside acknowledge");
	chk_axis_follow: assert property (scanTick && axisConfigured[1:0] == 2'b10 |=>
		axisFlags[0].permit == $past(axisIn[1].permit) && axisFlags[0].dirNeg ==
		$past(axisIn[1].dirNeg) && axisFlags[0].inPos == $past(axisIn[1].inPos))
		else $error("first logical axis flags do not follow their slot");
	chk_drive_code: assert property (scanTick && axisConfigured[1:0] == 2'b10
		&& !axisIn[1].fault |=> {axisFlags[0].driveHi, axisFlags[0].driveLo} ==
		$past(axisIn[1].drive))
		else $error("drive state pair wrong");
	chk_fault_low: assert property (scanTick && axisConfigured[4:0] == 5'b10110
		&& axisIn[4].fault |=> {axisFlags[2].driveHi, axisFlags[2].driveLo} == 2'h0)
		else $error("drive fault did not force state pair low");
	chk_unconf_zero: assert property (scanTick && !(&axisConfigured) |=>
		axisFlags[6] == 8'h00)
		else $error("flags of a missing axis not zero");
	chk_flags_hold: assert property (!scanTick |=> $stable(axisFlags[0]) &&
		$stable(spindleFlags[0]) && $stable(spindleFlags[1]))
		else $error("flags changed without a scan");
	chk_strobe_rise: assert property ($rose(tool_return_strobe) |-> $past(scanTick))
		else $error("tool strobe rose outside a scan");
	chk_strobe_fall: assert property ($fell(tool_return_strobe) && $past(rst_n)
		|-> $past(scanTick))
		else $error("tool strobe fell outside a scan");
	chk_rotary_flag: assert property (scanTick && spindleMode == csf_pkg::SPM_ROTARY
		|=> spindleFlags[0].extA || spindleFlags[1].extA)
		else $error("rotary flag missing");
	chk_stop_ok: assert property (scanTick && spindleMode == csf_pkg::SPM_CLOSED
		&& spindleStopped |=> spindleFlags[0].extB || spindleFlags[1].extB)
		else $error("stopped spindle without speed ok");

	// Main scenarios reached
	cov_rotary: cover property (scanTick && spindleMode == csf_pkg::SPM_ROTARY);
	cov_strobe: cover property ($rose(tool_return_strobe));
	cov_fault: cover property (scanTick && axisIn[4].fault);
endmodule
bind csf_status_flags csf_status_flags_chk u_chk (.sys_clk, .rst_n, .wbCyc, .wbStb,
	.wbDatR, .wbAck, .scanTick, .axisConfigured, .axisIn, .spindleMode, .spindleStopped,
	.axisFlags, .spindleFlags, .tool_return_strobe);

//--- sim/csf_status_flags_test.sv
// Self-checking bench for the axis and spindle status-flag block
`timescale 1ns/10ps
module csf_status_flags_test;
	logic                    sys_clk, rst_n, wbCyc, wbStb, wbWe, wbAck, scanTick;
	logic                    operatorReset, paramChange, spindleStopped, toolReturnValid;
	logic                    tool_return_strobe;
	logic [31:0]             wbAdr, wbDatW, wbDatR, rd;
	logic [3:0]              wbSel;
	logic [6:0]              axisConfigured;
	csf_pkg::csf_chan_in_t   axisIn [csf_pkg::AXES];
	csf_pkg::csf_chan_in_t   spindleIn;
	logic [15:0]             axisMoveMag [csf_pkg::AXES];
	logic [15:0]             axisGantryDiff [csf_pkg::AXES];
	logic [15:0]             axisLossUm [csf_pkg::AXES];
	csf_pkg::csf_spin_mode_t spindleMode;
	logic [15:0]             spindleSpeed;
	logic [7:0]              toolReturnCode, tool_return_code_reg;
	csf_pkg::csf_flags_t     axisFlags [csf_pkg::AXES];
	csf_pkg::csf_flags_t     spindleFlags [csf_pkg::SPINDLES];
	logic [72:0]             marks;
	int                      errors, compares, cycles;
	// Slot inputs: slots 0, 3 and 5 are absent but still busy, to catch leaks
	localparam logic [7:0]   SLOT_IN [7] = '{8'hCD, 8'h8D, 8'h44, 8'hCD, 8'hCA, 8'hCD, 8'h09};
	localparam logic [15:0]  MOVE [7] = '{16'h0, 16'h63, 16'h64, 16'h0, 16'hC8, 16'h0, 16'h0};
	localparam logic [15:0]  GANT [7] = '{16'h0, 16'h0, 16'h33, 16'h0, 16'h32, 16'h0, 16'h0};

	csf_status_flags u_dut (.*);
	csf_plc_model u_plc (.*);

	// ----------------------------------------------------------
	// Clock, timeout and verdict
	// ----------------------------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// A hang in a bus wait ends here instead of running forever
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			final_report();
		end
	end

	task automatic final_report;
		if (errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One classic cycle; held until ack is sampled, released at that edge
	task automatic wb_go(input logic we, input logic [31:0] adr, input logic [3:0] sel,
		input logic [31:0] dat);
		@(posedge sys_clk);
		{wbCyc, wbStb, wbWe} <= {2'b11, we};
		{wbAdr, wbSel, wbDatW} <= {adr, sel, dat};
		@(posedge sys_clk);
		while (wbAck !== 1'b1)
			@(posedge sys_clk);
		rd = wbDatR;
		{wbCyc, wbStb} <= 2'b00;
	endtask

	task automatic wr(input logic [31:0] adr, input logic [3:0] sel, input logic [31:0] dat);
		wb_go(1'b1, adr, sel, dat);
	endtask

	task automatic rdc(input string what, input logic [31:0] adr, input logic [31:0] exp);
		wb_go(1'b0, adr, 4'hF, 32'h0);
		chk(what, exp, rd);
	endtask

	// Scan pulse, then wait until the controller model has read the marks
	task automatic scan;
		@(posedge sys_clk);
		scanTick <= 1'b1;
		@(posedge sys_clk);
		scanTick <= 1'b0;
		@(posedge sys_clk);
		#1;
	endtask

	task automatic axis_step(input logic [7:0] pin, input logic [1:0] clr,
		input logic [15:0] loss, input logic [7:0] expB);
		@(posedge sys_clk);
		axisIn[1] <= csf_pkg::csf_chan_in_t'(pin);
		{operatorReset, paramChange} <= clr;
		axisLossUm[1] <= loss;
		@(posedge sys_clk);
		axisIn[1] <= csf_pkg::csf_chan_in_t'(8'h8D);
		{operatorReset, paramChange} <= 2'b00;
		scan();
		rdc("axis low register", 32'h14, {24'hC80332, expB});
	endtask

	task automatic spin_step(input csf_pkg::csf_spin_mode_t m, input logic [15:0] spd,
		input logic [7:0] pin, input logic [15:0] exp);
		@(posedge sys_clk);
		{spindleMode, spindleSpeed, spindleStopped} <= {m, spd, spd == 16'h0};
		spindleIn <= csf_pkg::csf_chan_in_t'(pin);
		@(posedge sys_clk);
		spindleIn <= csf_pkg::csf_chan_in_t'(pin & 8'hDF);
		scan();
		chk("spindle marks", {16'h0, exp}, {16'h0, marks[71:56]});
		rdc("spindle register", 32'h1C, {16'h0, exp});
	endtask

	task automatic tool_pulse(input logic [7:0] code);
		@(posedge sys_clk);
		{toolReturnValid, toolReturnCode} <= {1'b1, code};
		@(posedge sys_clk);
		toolReturnValid <= 1'b0;
	endtask

	// ----------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------
	initial
	begin
		{rst_n, wbCyc, wbStb, wbWe, scanTick, operatorReset, paramChange} = '0;
		{spindleStopped, toolReturnValid, wbAdr, wbDatW, wbSel, spindleSpeed} = '0;
		{toolReturnCode, errors, compares, cycles} = '0;
		axisConfigured = 7'b1010110;
		spindleMode = csf_pkg::SPM_OFF;
		spindleIn = '0;
		for (int k = 0; k < 7; k++)
		begin
			axisIn[k] = csf_pkg::csf_chan_in_t'(SLOT_IN[k]);
			axisMoveMag[k] = MOVE[k];
			axisGantryDiff[k] = GANT[k];
			axisLossUm[k] = 16'h0;
		end
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rdc("ctrl after reset", 32'h00, 32'h0);
		wr(32'h00, 4'hF, 32'hFFFF_FFFF);
		rdc("ctrl writable bits", 32'h00, 32'h1001);
		wr(32'h00, 4'hF, 32'h0);
		wr(32'h04, 4'h1, 32'hFFFF_FF64);
		wr(32'h04, 4'h2, 32'h0);
		rdc("min move lanes", 32'h04, 32'h64);
		wr(32'h08, 4'hF, 32'h32);
		wr(32'h0C, 4'hF, 32'h64);
		wr(32'h10, 4'hF, 32'hC8);
		rdc("unmapped", 32'h24, 32'h0);
		rdc("high address", 32'h100, 32'h0);
		scan();
		chk("axis marks low", 32'hC803_32D9, marks[31:0]);
		chk("axis marks high", 32'h0, {8'h0, marks[55:32]});
		wr(32'h14, 4'hF, 32'hFFFF_FFFF);
		rdc("axis read-only", 32'h14, 32'hC803_32D9);
		axis_step(8'hAD, 2'b00, 16'h0, 8'hDD);
		axis_step(8'h8D, 2'b00, 16'hA, 8'hDD);
		axis_step(8'h8D, 2'b00, 16'hB, 8'hD9);
		axis_step(8'h8D, 2'b00, 16'h0, 8'hD9);
		axis_step(8'hAD, 2'b00, 16'h0, 8'hDD);
		axis_step(8'hBD, 2'b00, 16'h0, 8'hD9);
		axis_step(8'hAD, 2'b00, 16'h0, 8'hDD);
		axis_step(8'h8D, 2'b10, 16'h0, 8'hD9);
		axis_step(8'hAD, 2'b00, 16'h0, 8'hDD);
		axis_step(8'h8D, 2'b01, 16'h0, 8'hD9);
		spin_step(csf_pkg::SPM_CLOSED, 16'h0, 8'hED, 16'h00DF);
		spin_step(csf_pkg::SPM_CW, 16'hC8, 8'hCD, 16'h0058);
		spin_step(csf_pkg::SPM_CCW, 16'h64, 8'hCD, 16'h0058);
		spin_step(csf_pkg::SPM_CW, 16'h63, 8'hCD, 16'h0018);
		spin_step(csf_pkg::SPM_CW, 16'hC9, 8'hCD, 16'h0018);
		spin_step(csf_pkg::SPM_ROTARY, 16'h0, 8'hCD, 16'h0038);
		wr(32'h00, 4'hF, 32'h1);
		spin_step(csf_pkg::SPM_CLOSED, 16'h0, 8'hED, 16'hDF38);
		spin_step(csf_pkg::SPM_CLOSED, 16'h0, 8'hCF, 16'hC738);
		tool_pulse(8'h5A);
		scan();
		rdc("tool return disabled", 32'h20, 32'h0);
		wr(32'h00, 4'hF, 32'h1001);
		tool_pulse(8'hA5);
		rdc("tool code", 32'h20, 32'hA5);
		chk("tool code pin", 32'hA5, {24'h0, tool_return_code_reg});
		scan();
		chk("strobe mark", 32'h1, {31'h0, marks[72]});
		rdc("tool strobe", 32'h20, 32'h1A5);
		scan();
		rdc("tool strobe ended", 32'h20, 32'hA5);
		final_report();
	end
endmodule
